// >>> include/flash_ctrl_pkg.sv
// Purpose: Shared constants and types for the flash controller register block
// Assumes: 32-bit APB data, 8-bit byte address, one aligned word per register
// Notes: Offsets are byte addresses; reset values match the register map
`default_nettype none
package flash_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_MASKED_STATUS = 8'h08;
  localparam logic [7:0] OFF_EVENT_MASK = 8'h0C;
  localparam logic [7:0] OFF_RAW_STATUS = 8'h10;
  localparam logic [7:0] OFF_LAST_ADDRESS = 8'h14;
  localparam logic [7:0] OFF_PROGRAM_ADDRESS = 8'h18;
  localparam logic [7:0] OFF_SIGNATURE = 8'h24;
  localparam logic [7:0] OFF_TRIM_A = 8'h28;
  localparam logic [7:0] OFF_TRIM_B = 8'h2C;
  localparam logic [7:0] OFF_WAKEUP_TRIM = 8'h30;
  localparam logic [7:0] OFF_PROGRAM_WORD_0 = 8'h40;
  localparam logic [7:0] OFF_PROGRAM_WORD_3 = 8'h4C;

  // Event bit positions, shared by mask, raw and masked status
  localparam int EVT_W = 6;
  localparam int EVT_FINISHED = 0;
  localparam int EVT_ACCEPTED = 1;
  localparam int EVT_BUSY_WRITE = 2;
  localparam int EVT_BAD_CODE = 3;
  localparam int EVT_CHECK_PASS = 4;
  localparam int EVT_ASLEEP = 5;

  // Reset values
  localparam logic [31:0] RST_COMMAND = 32'h0000_0000;
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [5:0] RST_EVENT_MASK = 6'h3F;
  localparam logic [5:0] RST_RAW_STATUS = 6'h00;
  localparam logic [31:0] RST_LAST_ADDRESS = 32'h0000_0000;
  localparam logic [31:0] RST_PROGRAM_ADDRESS = 32'h0000_0000;
  localparam logic [31:0] RST_SIGNATURE = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_TRIM_A = 32'h0B06_1515;
  localparam logic [31:0] RST_TRIM_B = 32'h0B15_6506;
  localparam logic [31:0] RST_WAKEUP_TRIM = 32'h0000_0011;
  localparam logic [31:0] RST_PROGRAM_WORD = 32'hFFFF_FFFF;

  // Address step per programmed word
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  // Command codes
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h11;
  localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE = 8'h22;
  localparam logic [7:0] CMD_SINGLE_PROGRAM = 8'h33;
  localparam logic [7:0] CMD_WHOLE_ARRAY_PROGRAM = 8'h44;
  localparam logic [7:0] CMD_WHOLE_ARRAY_CHECK = 8'h55;
  localparam logic [7:0] CMD_MULTI_WORD_PROGRAM = 8'hCC;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_state_e;

  // Request towards the flash array sequencer
  typedef struct packed {
    logic start;
    logic [7:0] code;
    logic [31:0] addr;
  } array_req_s;

  // Status coming back from the flash array sequencer
  typedef struct packed {
    logic done;
    logic asleep;
    logic check_ok;
    logic word_done;
    logic sig_valid;
    logic [31:0] signature;
  } array_rsp_s;

  typedef logic [3:0][31:0] program_words_t;

  typedef struct packed {
    seq_state_e state;
    logic [31:0] command;
    logic [31:0] config_word;
    logic [5:0] mask;
    logic [5:0] raw;
    logic [31:0] last_addr;
    logic [31:0] prog_addr;
    logic [31:0] signature;
    logic [31:0] trim_a;
    logic [31:0] trim_b;
    logic [31:0] trim_w;
    program_words_t words;
    array_req_s req;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctrl_state_s;

  localparam ctrl_state_s STATE_RESET = '{
    state: SEQ_IDLE,
    command: RST_COMMAND,
    config_word: RST_CONFIG,
    mask: RST_EVENT_MASK,
    raw: RST_RAW_STATUS,
    last_addr: RST_LAST_ADDRESS,
    prog_addr: RST_PROGRAM_ADDRESS,
    signature: RST_SIGNATURE,
    trim_a: RST_TRIM_A,
    trim_b: RST_TRIM_B,
    trim_w: RST_WAKEUP_TRIM,
    words: {4{RST_PROGRAM_WORD}},
    req: '{start: 1'b0, code: 8'h00, addr: 32'h0000_0000},
    irq: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

endpackage
`default_nettype wire

// >>> design/flash_ctrl_regs.sv
// Purpose: APB register file and command front end of the flash controller
// Assumes: Flash array sequencer sits outside and answers on array_rsp_in
// Notes: One packed state struct, one always_comb, two always_ff (reset release and state)
`default_nettype none
module flash_ctrl_regs (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Flash array side
  input wire flash_ctrl_pkg::array_rsp_s array_rsp_in,
  input wire logic [31:0] flash_last_addr_in,
  output flash_ctrl_pkg::array_req_s array_req_out,
  output flash_ctrl_pkg::program_words_t program_words_out,
  output logic [31:0] config_out,
  output logic [31:0] trim_a_out,
  output logic [31:0] trim_b_out,
  output logic [31:0] wakeup_trim_out,
  // Interrupt
  output logic irq_out
);

  // Reset release synchroniser; assertion stays asynchronous
  logic [1:0] rst_sync_q;
  logic rst_b;

  // Whole block state and its next value
  flash_ctrl_pkg::ctrl_state_s st_q;
  flash_ctrl_pkg::ctrl_state_s st_d;

  // Bus phase decode
  logic acc_start;
  logic wr_take;
  logic [5:0] evt_set;
  logic [5:0] evt_clr;
  logic [7:0] wr_code;

  // Legal command codes; anything else raises the bad-code event
  function automatic logic code_is_legal(input logic [7:0] code);
    logic ok;
    ok = 1'b0;
    unique case (code)
      flash_ctrl_pkg::CMD_PAGE_ERASE,
      flash_ctrl_pkg::CMD_WHOLE_ARRAY_ERASE,
      flash_ctrl_pkg::CMD_SINGLE_PROGRAM,
      flash_ctrl_pkg::CMD_WHOLE_ARRAY_PROGRAM,
      flash_ctrl_pkg::CMD_WHOLE_ARRAY_CHECK,
      flash_ctrl_pkg::CMD_MULTI_WORD_PROGRAM: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Map check, used by the read path, the write path and the error answer
  function automatic logic addr_is_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      flash_ctrl_pkg::OFF_COMMAND,
      flash_ctrl_pkg::OFF_CONFIG,
      flash_ctrl_pkg::OFF_MASKED_STATUS,
      flash_ctrl_pkg::OFF_EVENT_MASK,
      flash_ctrl_pkg::OFF_RAW_STATUS,
      flash_ctrl_pkg::OFF_LAST_ADDRESS,
      flash_ctrl_pkg::OFF_PROGRAM_ADDRESS,
      flash_ctrl_pkg::OFF_SIGNATURE,
      flash_ctrl_pkg::OFF_TRIM_A,
      flash_ctrl_pkg::OFF_TRIM_B,
      flash_ctrl_pkg::OFF_WAKEUP_TRIM: hit = 1'b1;
      default: hit = (addr >= flash_ctrl_pkg::OFF_PROGRAM_WORD_0) &&
                     (addr <= flash_ctrl_pkg::OFF_PROGRAM_WORD_3) &&
                     (addr[1:0] == 2'h0);
    endcase
    return hit;
  endfunction

  // Read mux over the current state
  function automatic logic [31:0] read_word(input flash_ctrl_pkg::ctrl_state_s s,
                                            input logic [7:0] addr);
    logic [31:0] val;
    val = 32'h0000_0000;
    unique case (addr)
      flash_ctrl_pkg::OFF_COMMAND: val = s.command;
      flash_ctrl_pkg::OFF_CONFIG: val = s.config_word;
      flash_ctrl_pkg::OFF_MASKED_STATUS: val = {26'h000_0000, s.raw & s.mask};
      flash_ctrl_pkg::OFF_EVENT_MASK: val = {26'h000_0000, s.mask};
      flash_ctrl_pkg::OFF_RAW_STATUS: val = {26'h000_0000, s.raw};
      flash_ctrl_pkg::OFF_LAST_ADDRESS: val = s.last_addr;
      flash_ctrl_pkg::OFF_PROGRAM_ADDRESS: val = s.prog_addr;
      flash_ctrl_pkg::OFF_SIGNATURE: val = s.signature;
      flash_ctrl_pkg::OFF_TRIM_A: val = s.trim_a;
      flash_ctrl_pkg::OFF_TRIM_B: val = s.trim_b;
      flash_ctrl_pkg::OFF_WAKEUP_TRIM: val = s.trim_w;
      default:
      begin
        if (addr_is_mapped(addr))
        begin
          val = s.words[addr[3:2]];
        end
      end
    endcase
    return val;
  endfunction

  // Reset release through two flops so no flop leaves reset mid-edge
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_b = rst_sync_q[1];

  // Access phase first cycle, and the edge where a write lands
  assign acc_start = psel_in && penable_in && !st_q.pready;
  assign wr_take = psel_in && penable_in && st_q.pready && pwrite_in;
  assign wr_code = pwdata_in[7:0];

  // Next-state logic for bus, events and command front end
  always_comb
  begin
    st_d = st_q;
    evt_set = 6'h00;
    evt_clr = 6'h00;

    // Pulse outputs last one cycle
    st_d.req.start = 1'b0;

    // Registered answer: pready rises one cycle into the access phase
    st_d.pready = acc_start;
    if (acc_start)
    begin
      st_d.pslverr = !addr_is_mapped(paddr_in);
      st_d.prdata = pwrite_in ? 32'h0000_0000 : read_word(st_q, paddr_in);
    end
    else
    begin
      st_d.pslverr = 1'b0;
      st_d.prdata = 32'h0000_0000;
    end

    // Size indication follows the array every cycle, never software
    st_d.last_addr = flash_last_addr_in;

    // Register writes take effect on the completing edge only
    if (wr_take)
    begin
      unique case (paddr_in)
        flash_ctrl_pkg::OFF_COMMAND:
        begin
          st_d.command = pwdata_in;
          if (!code_is_legal(wr_code))
          begin
            evt_set[flash_ctrl_pkg::EVT_BAD_CODE] = 1'b1;
          end
          else if (st_q.state == flash_ctrl_pkg::SEQ_BUSY)
          begin
            evt_set[flash_ctrl_pkg::EVT_BUSY_WRITE] = 1'b1;
          end
          else if (array_rsp_in.asleep)
          begin
            // Array cannot take the command while asleep; nothing starts
            evt_set[flash_ctrl_pkg::EVT_ASLEEP] = 1'b1;
          end
          else
          begin
            st_d.state = flash_ctrl_pkg::SEQ_BUSY;
            st_d.req.start = 1'b1;
            st_d.req.code = wr_code;
            st_d.req.addr = st_q.prog_addr;
            evt_set[flash_ctrl_pkg::EVT_ACCEPTED] = 1'b1;
          end
        end
        flash_ctrl_pkg::OFF_CONFIG: st_d.config_word = pwdata_in;
        flash_ctrl_pkg::OFF_MASKED_STATUS:
        begin
          evt_clr = pwdata_in[5:0];
        end
        flash_ctrl_pkg::OFF_EVENT_MASK:
        begin
          st_d.mask = pwdata_in[5:0];
        end
        flash_ctrl_pkg::OFF_RAW_STATUS:
        begin
          evt_clr = pwdata_in[5:0];
        end
        flash_ctrl_pkg::OFF_PROGRAM_ADDRESS: st_d.prog_addr = pwdata_in;
        flash_ctrl_pkg::OFF_TRIM_A: st_d.trim_a = pwdata_in;
        flash_ctrl_pkg::OFF_TRIM_B: st_d.trim_b = pwdata_in;
        flash_ctrl_pkg::OFF_WAKEUP_TRIM: st_d.trim_w = pwdata_in;
        default:
        begin
          // Read-only and unmapped words swallow the write
          if (addr_is_mapped(paddr_in) && paddr_in >= flash_ctrl_pkg::OFF_PROGRAM_WORD_0)
          begin
            st_d.words[paddr_in[3:2]] = pwdata_in;
          end
        end
      endcase
    end

    // Array steps the address per programmed word; hardware beats software
    if (array_rsp_in.word_done)
    begin
      st_d.prog_addr = st_q.prog_addr + flash_ctrl_pkg::ADDR_STEP;
    end

    // Signature only changes when the array hands over a new one
    if (array_rsp_in.sig_valid)
    begin
      st_d.signature = array_rsp_in.signature;
    end

    // Completion ends the busy phase and reports the outcome
    if (st_q.state == flash_ctrl_pkg::SEQ_BUSY && array_rsp_in.done)
    begin
      st_d.state = flash_ctrl_pkg::SEQ_IDLE;
      evt_set[flash_ctrl_pkg::EVT_FINISHED] = 1'b1;
      if (st_q.req.code == flash_ctrl_pkg::CMD_WHOLE_ARRAY_CHECK && array_rsp_in.check_ok)
      begin
        evt_set[flash_ctrl_pkg::EVT_CHECK_PASS] = 1'b1;
      end
    end

    // Set wins over a same-cycle clear so no event is lost
    st_d.raw = (st_q.raw & ~evt_clr) | evt_set;

    // Interrupt level from the next raw and mask, so it tracks them exactly
    st_d.irq = |(st_d.raw & st_d.mask);
  end

  // Single state register
  always_ff @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= flash_ctrl_pkg::STATE_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // All outputs straight from state flops
  assign prdata_out = st_q.prdata;
  assign pready_out = st_q.pready;
  assign pslverr_out = st_q.pslverr;
  assign array_req_out = st_q.req;
  assign program_words_out = st_q.words;
  assign config_out = st_q.config_word;
  assign trim_a_out = st_q.trim_a;
  assign trim_b_out = st_q.trim_b;
  assign wakeup_trim_out = st_q.trim_w;
  assign irq_out = st_q.irq;

endmodule
`default_nettype wire

// >>> test/flash_ctrl_regs_properties.sv
// Purpose: Bus and command-path checks for the flash register block
// Assumes: Sees only the block's ports; the bus master holds its request
// Notes: Reserved-bit and last-address checks ride on completed reads
`default_nettype none
module flash_ctrl_regs_properties (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Array side
  input wire logic [31:0] flash_last_addr_in,
  input wire flash_ctrl_pkg::array_req_s array_req_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Completed read, bus still held by the master
  wire logic rd_done = pready_out && psel_in && !pwrite_in;

  property p_answer;
    psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not a single cycle");
  property p_unmapped;
    pready_out && psel_in && !(paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
      8'h14, 8'h18, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h40, 8'h44, 8'h48, 8'h4C}) |-> pslverr_out;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without error");
  property p_ro_ok;
    pready_out && psel_in && paddr_in inside {8'h14, 8'h24} |-> !pslverr_out;
  endproperty
  a_ro_ok: assert property (p_ro_ok)
    else $error("read-only access flagged as error");
  property p_reserved;
    rd_done && paddr_in inside {8'h08, 8'h0C, 8'h10} |-> prdata_out[31:6] == 26'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved event bits not zero");
  property p_last;
    rd_done && paddr_in == 8'h14 |-> prdata_out == $past(flash_last_addr_in, 2);
  endproperty
  a_last: assert property (p_last)
    else $error("last address read wrong");
  property p_start_cause;
    array_req_out.start |-> $past(pready_out && psel_in && pwrite_in && paddr_in == 8'h00);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without command write");
  property p_start_code;
    array_req_out.start |-> array_req_out.code inside {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hCC};
  endproperty
  a_start_code: assert property (p_start_code)
    else $error("illegal code started");
  property p_start_pulse;
    array_req_out.start |=> !array_req_out.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
endmodule

bind flash_ctrl_regs flash_ctrl_regs_properties i_flash_ctrl_regs_properties (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .flash_last_addr_in(flash_last_addr_in), .array_req_out(array_req_out));
`default_nettype wire

// >>> test/flash_ctrl_regs_test.sv
// Purpose: Self-checking bench for the flash register block
// Assumes: Bench plays both the bus master and the array sequencer
// Notes: Array responses are pulsed by hand between bus accesses
`default_nettype none
module flash_ctrl_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] LAST = 32'h0003_FFFC;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic irq_out;
  flash_ctrl_pkg::program_words_t words_seen;
  logic [31:0] cfg_seen;
  logic [31:0] trim_a_seen;
  logic [31:0] trim_b_seen;
  logic [31:0] wake_seen;
  flash_ctrl_pkg::array_rsp_s rsp = '0;
  flash_ctrl_pkg::array_req_s req;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] codes [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hCC};
  logic [7:0] rw [8] = '{8'h18, 8'h28, 8'h2C, 8'h30, 8'h40, 8'h44, 8'h48, 8'h4C};

  flash_ctrl_regs i_flash_ctrl_regs (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .array_rsp_in(rsp), .flash_last_addr_in(LAST), .array_req_out(req),
    .program_words_out(words_seen), .config_out(cfg_seen), .trim_a_out(trim_a_seen),
    .trim_b_out(trim_b_seen), .wakeup_trim_out(wake_seen), .irq_out(irq_out));

  // 50 MHz clock
  always #10 clk_in = ~clk_in;

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits on pready as long as it takes, the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
    end
    while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Pulse {done, word_done, sig_valid} for one cycle
  task automatic pulse(input logic [2:0] p);
    @(posedge clk_in);
    {rsp.done, rsp.word_done, rsp.sig_valid} <= p;
    @(posedge clk_in);
    {rsp.done, rsp.word_done, rsp.sig_valid} <= 3'b000;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rdc(8'h0C, 32'h0000_003F);
    rdc(8'h10, 32'h0000_0000);
    rdc(8'h18, 32'h0000_0000);
    rdc(8'h24, 32'hFFFF_FFFF);
    rdc(8'h28, 32'h0B06_1515);
    rdc(8'h2C, 32'h0B15_6506);
    rdc(8'h30, 32'h0000_0011);
    for (int i = 0; i < 4; i++)
      rdc(8'h40 + 8'(4 * i), 32'hFFFF_FFFF);
    rdc(8'h14, LAST);
    $display("reset values done");
    // Writable words keep data; read-only ones and the unmapped error are tried further down
    for (int i = 0; i < 8; i++)
    begin
      wr(rw[i], 32'hA5C3_0000 | 32'(i));
      rdc(rw[i], 32'hA5C3_0000 | 32'(i));
    end
    // Trim and data words also reach the array side
    chk(trim_a_seen, 32'hA5C3_0001);
    chk(trim_b_seen, 32'hA5C3_0002);
    chk(wake_seen, 32'hA5C3_0003);
    for (int i = 0; i < 4; i++)
      chk(words_seen[i], 32'hA5C3_0004 | 32'(i));
    wr(8'h04, 32'h5A5A_0F0F);
    rdc(8'h04, 32'h5A5A_0F0F);
    chk(cfg_seen, 32'h5A5A_0F0F);
    wr(8'h14, 32'h0000_0000);
    rdc(8'h14, LAST);
    wr(8'h24, 32'h0000_0000);
    rdc(8'h24, 32'hFFFF_FFFF);
    rdc(8'h1C, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    wr(8'h0C, 32'hFFFF_FFFF);
    rdc(8'h0C, 32'h0000_003F);
    wr(8'h10, 32'hFFFF_FFFF);
    rdc(8'h10, 32'h0000_0000);
    $display("access tests done");
    // Masked illegal code, then unmask, then clear
    wr(8'h0C, 32'h0000_0000);
    wr(8'h00, 32'h0000_0077);
    rdc(8'h10, 32'h0000_0008);
    rdc(8'h08, 32'h0000_0000);
    chk(32'(irq_out), 32'h0000_0000);
    wr(8'h0C, 32'h0000_0008);
    rdc(8'h08, 32'h0000_0008);
    chk(32'(irq_out), 32'h0000_0001);
    wr(8'h08, 32'h0000_0008);
    rdc(8'h10, 32'h0000_0000);
    chk(32'(irq_out), 32'h0000_0000);
    // Command while the array sleeps
    wr(8'h0C, 32'h0000_003F);
    rsp.asleep <= 1'b1;
    wr(8'h00, 32'h0000_0011);
    rsp.asleep <= 1'b0;
    rdc(8'h10, 32'h0000_0020);
    wr(8'h10, 32'h0000_0020);
    $display("event tests done");
    // Every legal code, a second write while busy, then completion
    rsp.check_ok <= 1'b1;
    foreach (codes[i])
    begin
      wr(8'h00, 32'(codes[i]));
      @(negedge clk_in);
      chk(32'({req.start, req.code}), 32'({1'b1, codes[i]}));
      chk(req.addr, 32'hA5C3_0000);
      wr(8'h00, 32'(codes[i]));
      pulse(3'b100);
      rdc(8'h10, codes[i] == 8'h55 ? 32'h0000_0017 : 32'h0000_0007);
      chk(32'(irq_out), 32'h0000_0001);
      wr(8'h08, 32'h0000_003F);
      rdc(8'h10, 32'h0000_0000);
    end
    wr(8'h18, 32'h0000_0100);
    pulse(3'b010);
    rdc(8'h18, 32'h0000_0104);
    rsp.signature <= 32'h1234_ABCD;
    pulse(3'b001);
    rdc(8'h24, 32'h1234_ABCD);
    $display("command tests done");
    results();
  end

  // Watchdog
  initial
  begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
